// ==== logic/sram_port_pkg.sv ====
package sram_port_pkg;

  // ****************************************************************
  // Array shape
  // ****************************************************************
  localparam int ADDR_W_DEFAULT = 15;
  localparam int DATA_W_DEFAULT = 9;

  // ****************************************************************
  // Read latency in port clock cycles
  // ****************************************************************
  localparam int LAT_FT_CYCLES = 1;
  localparam int LAT_PIPE_CYCLES = 2;

  // ****************************************************************
  // Controller register map
  // ****************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam int CTRL_LAT_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int CMD_ADV_BIT = 2;
  localparam int CMD_CLR_BIT = 3;
  localparam int CMD_DESEL_BIT = 4;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDONE_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Controller sequence
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } host_state_t;

endpackage

// ==== logic/sram_port_if.sv ====
`timescale 1ns/100ps
interface sram_port_if #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEFAULT
);
  logic clk_en;
  logic [ADDR_W-1:0] addr;
  logic addr_load_strobe_n;
  logic chip_sel_lowactive;
  logic chip_sel_highactive;
  logic burst_advance_n;
  logic burst_clear_n;
  logic oe_n;
  logic wr_n;
  logic latency_select;
  logic [DATA_W-1:0] host_dq;
  logic host_dq_oe_n;
  logic [DATA_W-1:0] dev_dq;
  logic dev_dq_oe_n;
  logic [DATA_W-1:0] dq;

  // ****************************************************************
  // Data wire resolution
  // ****************************************************************
  // An undriven wire reads inverted, so a late sample shows up; no Z is modelled
  assign dq = !dev_dq_oe_n ? dev_dq : !host_dq_oe_n ? host_dq : ~host_dq;

  modport device
  (
    input clk_en, addr, addr_load_strobe_n, chip_sel_lowactive, chip_sel_highactive,
    input burst_advance_n, burst_clear_n, oe_n, wr_n, latency_select, dq,
    output dev_dq, dev_dq_oe_n
  );

  modport host
  (
    output clk_en, addr, addr_load_strobe_n, chip_sel_lowactive, chip_sel_highactive,
    output burst_advance_n, burst_clear_n, oe_n, wr_n, latency_select,
    output host_dq, host_dq_oe_n,
    input dq
  );
endinterface

// ==== logic/burst_counter.sv ====
`timescale 1ns/100ps
module burst_counter #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port clock edge
  input wire logic step,
  // Counter controls
  input wire logic load_n,
  input wire logic advance_n,
  input wire logic clear_n,
  input wire logic [ADDR_W-1:0] load_value,
  // Counter state
  output logic [ADDR_W-1:0] count,
  output logic [ADDR_W-1:0] next_count
);

  // ****************************************************************
  // Next value
  // ****************************************************************
  // Clear beats load, load beats advance; the sum wraps at the top
  wire [ADDR_W-1:0] count_plus = count + 1'b1;  // [RULE_14]
  assign next_count = !clear_n ? '0 :  // [RULE_08] [RULE_09]
                      !load_n ? load_value :  // [RULE_03]
                      !advance_n ? count_plus :  // [RULE_06] [RULE_07]
                      count;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= '0;
    else if (step)
      count <= next_count;  // [RULE_18]
  end

endmodule

// ==== logic/sram_port_device.sv ====
`timescale 1ns/100ps
module sram_port_device #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEFAULT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Memory port
  sram_port_if.device port,
  // Status
  output logic power_down,
  output logic [ADDR_W-1:0] burst_addr
);

  localparam int DEPTH = 1 << ADDR_W;  // [RULE_01]

  // ****************************************************************
  // Array and access decode
  // ****************************************************************
  logic [DATA_W-1:0] mem [0:DEPTH-1];  // [RULE_10]
  logic [DATA_W-1:0] stage_data;
  logic stage_valid;
  logic drive_valid;
  logic [ADDR_W-1:0] count;
  logic [ADDR_W-1:0] access_addr;

  // A stopped port clock is an idle enable; only the output enable moves without it
  wire step = port.clk_en;  // [RULE_05] [RULE_18]
  wire selected = !port.chip_sel_lowactive && port.chip_sel_highactive;  // [RULE_04]
  wire do_write = step && selected && !port.wr_n;  // [RULE_12]
  wire do_read = step && selected && port.wr_n;  // [RULE_12]
  wire [DATA_W-1:0] array_word = mem[access_addr];

  // Pipelined output only drives if this cycle is selected again
  wire next_drive = port.latency_select ? (stage_valid && selected) : do_read;  // [RULE_13] [RULE_16]
  wire [DATA_W-1:0] next_dq = port.latency_select ? stage_data : array_word;  // [RULE_19]
  wire drive_now = step ? next_drive : drive_valid;

  // ****************************************************************
  // Burst counter
  // ****************************************************************
  // The loaded address is used directly in the cycle it is strobed
  burst_counter #(
    .ADDR_W(ADDR_W)
  ) counter
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(step),
    .load_n(port.addr_load_strobe_n),  // [RULE_02]
    .advance_n(port.burst_advance_n),
    .clear_n(port.burst_clear_n),
    .load_value(port.addr),
    .count(count),
    .next_count(access_addr)
  );

  assign burst_addr = count;

  // ****************************************************************
  // Array write
  // ****************************************************************
  // Same-location writes from two ports are not arbitrated here
  always_ff @(posedge aclk)
  begin
    if (do_write)
      mem[access_addr] <= port.dq;  // [RULE_12] [RULE_17]
  end

  // ****************************************************************
  // Read stages
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage_data <= '0;
      stage_valid <= 1'b0;
      drive_valid <= 1'b0;
      port.dev_dq <= '0;
    end
    else if (step)
    begin
      stage_data <= array_word;
      stage_valid <= do_read;
      drive_valid <= next_drive;
      port.dev_dq <= next_dq;  // [RULE_13]
    end
  end

  // ****************************************************************
  // Output enable and power state
  // ****************************************************************
  // The enable follows the host's enable every cycle, even with the clock stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port.dev_dq_oe_n <= 1'b1;
      power_down <= 1'b1;
    end
    else
    begin
      port.dev_dq_oe_n <= !(drive_now && !port.oe_n);  // [RULE_11]
      if (step)
        power_down <= !selected;  // [RULE_15]
    end
  end

endmodule

// ==== logic/sram_port_host.sv ====
// Function
// RULE_01 - Address width 15/16/17 by depth parameter
// RULE_02 - Load strobe low selects external address
// RULE_03 - Load strobe also loads burst counter
// RULE_04 - Selected only when both chip selects active
// RULE_05 - Works with free-running or stopped clock
// RULE_06 - Advance low increments counter each edge
// RULE_07 - Advance ignored during load or clear
// RULE_08 - Clear low sets counter to zero
// RULE_09 - Clear has highest priority
// RULE_10 - Data width 8 or 9 by parameter
// RULE_11 - Drive data only on read with enable
// RULE_12 - Write-not-read low writes, high reads
// RULE_13 - Latency select: low flow-through, high pipelined
// RULE_14 - Counter spans whole array and wraps
// RULE_15 - One deselected cycle powers the port down
// RULE_16 - Pipelined needs one selected cycle before driving
// RULE_17 - Hosts avoid simultaneous same-location writes
// RULE_18 - Inputs sampled on own port clock edge
// RULE_19 - Pipelined read data one cycle later
`timescale 1ns/100ps
module sram_port_host #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEFAULT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [sram_port_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [sram_port_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port
  sram_port_if.host port
);

  sram_port_pkg::host_state_t state;
  logic aw_got;
  logic w_got;
  logic [sram_port_pkg::AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [1:0] ctrl;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rdone;
  logic [4:0] cmd;
  logic [1:0] wait_cnt;

  // ****************************************************************
  // Write channel decode
  // ****************************************************************
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got || aw_hs;
  wire w_have = w_got || w_hs;
  wire do_wr = aw_have && w_have && !s_axi_bvalid;
  wire [sram_port_pkg::AXI_ADDR_W-1:0] wr_addr = aw_hs ? s_axi_awaddr : aw_addr_q;
  wire [31:0] wr_data = w_hs ? s_axi_wdata : w_data_q;
  wire next_bvalid = do_wr || (s_axi_bvalid && !s_axi_bready);
  wire hit_ctrl = wr_addr == sram_port_pkg::OFF_CTRL;
  wire hit_addr = wr_addr == sram_port_pkg::OFF_ADDR;
  wire hit_wdata = wr_addr == sram_port_pkg::OFF_WDATA;
  wire hit_cmd = wr_addr == sram_port_pkg::OFF_CMD;
  wire wr_ok = hit_ctrl || hit_addr || hit_wdata || hit_cmd;
  // A command while a port cycle runs is accepted on the bus and dropped
  wire launch = do_wr && |s_axi_wstrb && hit_cmd && state == sram_port_pkg::ST_IDLE;
  wire is_write = cmd[sram_port_pkg::CMD_WRITE_BIT];
  wire is_desel = cmd[sram_port_pkg::CMD_DESEL_BIT];

  // ****************************************************************
  // Read channel decode
  // ****************************************************************
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
  wire [31:0] status_word = {30'h0000_0000, rdone, state != sram_port_pkg::ST_IDLE};
  wire rd_ok = s_axi_araddr == sram_port_pkg::OFF_CTRL || s_axi_araddr == sram_port_pkg::OFF_ADDR
            || s_axi_araddr == sram_port_pkg::OFF_WDATA || s_axi_araddr == sram_port_pkg::OFF_CMD
            || s_axi_araddr == sram_port_pkg::OFF_RDATA || s_axi_araddr == sram_port_pkg::OFF_STATUS;
  wire [31:0] rd_word =
    s_axi_araddr == sram_port_pkg::OFF_CTRL ? {30'h0000_0000, ctrl} :
    s_axi_araddr == sram_port_pkg::OFF_ADDR ? 32'(addr_reg) :
    s_axi_araddr == sram_port_pkg::OFF_WDATA ? 32'(wdata_reg) :
    s_axi_araddr == sram_port_pkg::OFF_CMD ? 32'(cmd) :
    s_axi_araddr == sram_port_pkg::OFF_RDATA ? 32'(rdata_reg) :
    s_axi_araddr == sram_port_pkg::OFF_STATUS ? status_word : 32'h0000_0000;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sram_port_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= sram_port_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_got <= aw_have && !do_wr;
      w_got <= w_have && !do_wr;
      if (aw_hs)
        aw_addr_q <= s_axi_awaddr;
      if (w_hs)
        w_data_q <= s_axi_wdata;
      s_axi_awready <= !(aw_have && !do_wr) && !next_bvalid;
      s_axi_wready <= !(w_have && !do_wr) && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_wr)
        s_axi_bresp <= wr_ok ? sram_port_pkg::RESP_OKAY : sram_port_pkg::RESP_SLVERR;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs)
      begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? sram_port_pkg::RESP_OKAY : sram_port_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Byte strobes are honoured only as whole-word writes for simplicity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= sram_port_pkg::CTRL_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
      cmd <= '0;
    end
    else if (do_wr && |s_axi_wstrb)
    begin
      if (hit_ctrl)
        ctrl <= wr_data[1:0];
      if (hit_addr)
        addr_reg <= wr_data[ADDR_W-1:0];
      if (hit_wdata)
        wdata_reg <= wr_data[DATA_W-1:0];
      if (launch)
        cmd <= wr_data[4:0];
    end
  end

  // ****************************************************************
  // Port sequence
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= sram_port_pkg::ST_IDLE;
      wait_cnt <= 2'h0;
      rdone <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      case (state)
        sram_port_pkg::ST_IDLE:
          if (launch)
          begin
            state <= sram_port_pkg::ST_ISSUE;
            rdone <= 1'b0;
          end
        sram_port_pkg::ST_ISSUE:
        begin
          wait_cnt <= ctrl[sram_port_pkg::CTRL_LAT_BIT]
                      ? 2'(sram_port_pkg::LAT_PIPE_CYCLES - 1)
                      : 2'(sram_port_pkg::LAT_FT_CYCLES - 1);  // [RULE_19]
          state <= (is_write || is_desel) ? sram_port_pkg::ST_DONE : sram_port_pkg::ST_WAIT;
        end
        sram_port_pkg::ST_WAIT:
          if (wait_cnt == 2'h0)
          begin
            rdata_reg <= port.dq;
            rdone <= 1'b1;
            state <= sram_port_pkg::ST_DONE;
          end
          else
            wait_cnt <= wait_cnt - 2'h1;
        default:
          state <= sram_port_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Pins are registered from the next state, so they change with it; the issue cycle is the one after launch
  wire next_issue = state == sram_port_pkg::ST_IDLE && launch;
  wire next_wait = (state == sram_port_pkg::ST_ISSUE && !is_write && !is_desel)
                   || (state == sram_port_pkg::ST_WAIT && wait_cnt != 2'h0);
  wire next_sel = (next_issue && !wr_data[sram_port_pkg::CMD_DESEL_BIT]) || next_wait;
  wire next_wr = next_issue && wr_data[sram_port_pkg::CMD_WRITE_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port.clk_en <= 1'b0;
      port.addr <= '0;
      port.addr_load_strobe_n <= 1'b1;
      port.chip_sel_lowactive <= 1'b1;
      port.chip_sel_highactive <= 1'b0;
      port.burst_advance_n <= 1'b1;
      port.burst_clear_n <= 1'b1;
      port.oe_n <= 1'b1;
      port.wr_n <= 1'b1;
      port.latency_select <= 1'b0;
      port.host_dq <= '0;
      port.host_dq_oe_n <= 1'b1;
    end
    else
    begin
      // Without the run bit the port clock only ticks for a command
      port.clk_en <= next_issue || next_wait || ctrl[sram_port_pkg::CTRL_RUN_BIT];  // [RULE_05]
      port.addr <= addr_reg;
      port.addr_load_strobe_n <= !(next_issue && wr_data[sram_port_pkg::CMD_LOAD_BIT]);  // [RULE_02]
      port.chip_sel_lowactive <= !next_sel;  // [RULE_04]
      port.chip_sel_highactive <= next_sel;  // [RULE_04]
      port.burst_advance_n <= !(next_issue && wr_data[sram_port_pkg::CMD_ADV_BIT]);
      port.burst_clear_n <= !(next_issue && wr_data[sram_port_pkg::CMD_CLR_BIT]);
      port.oe_n <= !(next_sel && !next_wr);  // [RULE_11]
      port.wr_n <= !next_wr;  // [RULE_12]
      port.latency_select <= ctrl[sram_port_pkg::CTRL_LAT_BIT];
      port.host_dq <= wdata_reg;
      port.host_dq_oe_n <= !next_wr;
    end
  end

endmodule

// ==== tb/sram_port_props.sv ====
`timescale 1ns/100ps
module sram_port_props #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEFAULT
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Port pins
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic addr_load_strobe_n,
  input wire logic chip_sel_lowactive,
  input wire logic chip_sel_highactive,
  input wire logic burst_advance_n,
  input wire logic burst_clear_n,
  input wire logic oe_n,
  input wire logic wr_n,
  input wire logic latency_select,
  input wire logic dev_dq_oe_n,
  // Device status
  input wire logic power_down,
  input wire logic [ADDR_W-1:0] burst_addr
);
  // ****************************************************************
  // Port edge decode
  // ****************************************************************
  wire selected = !chip_sel_lowactive && chip_sel_highactive;
  wire ft_read = clk_en && selected && wr_n && !oe_n && !latency_select;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // Counter and output checks
  // ****************************************************************
  a_clear_first: assert property (clk_en && !burst_clear_n |=> burst_addr == '0)
    else $error("counter not zero after clear");
  a_load_takes_addr: assert property (clk_en && burst_clear_n && !addr_load_strobe_n
    |=> burst_addr == $past(addr)) else $error("counter did not load address");
  a_advance_step: assert property (clk_en && burst_clear_n && addr_load_strobe_n
    && !burst_advance_n |=> burst_addr == ADDR_W'($past(burst_addr) + 1'b1))
    else $error("counter did not advance by one");
  a_hold_off_edge: assert property (!clk_en |=> $stable(burst_addr))
    else $error("counter moved without a port edge");
  a_desel_power: assert property (clk_en && !selected |=> power_down)
    else $error("no power down after deselect");
  a_oe_gates_drive: assert property (oe_n |=> dev_dq_oe_n)
    else $error("data driven while output enable high");
  a_ft_drive: assert property (ft_read |=> !dev_dq_oe_n)
    else $error("flow-through read not driven");
  a_pipe_wake: assert property (clk_en && latency_select && power_down |=> dev_dq_oe_n)
    else $error("pipelined output driven right after deselect");

  c_wrap: cover property (clk_en && !burst_advance_n && burst_addr == '1);
  c_ft_read: cover property (ft_read);
  c_pipe_drive: cover property (latency_select && !dev_dq_oe_n);
endmodule

// ==== tb/sync_dual_port_ram_port_test.sv ====
`timescale 1ns/100ps
module sync_dual_port_ram_port_test;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  localparam int AW = 15;
  localparam int DW = 9;
  localparam logic [31:0] C_WR = 32'h0000_0001 << sram_port_pkg::CMD_WRITE_BIT;
  localparam logic [31:0] C_LD = 32'h0000_0001 << sram_port_pkg::CMD_LOAD_BIT;
  localparam logic [31:0] C_ADV = 32'h0000_0001 << sram_port_pkg::CMD_ADV_BIT;
  localparam logic [31:0] C_CLR = 32'h0000_0001 << sram_port_pkg::CMD_CLR_BIT;
  localparam logic [31:0] C_DES = 32'h0000_0001 << sram_port_pkg::CMD_DESEL_BIT;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic power_down;
  logic [AW-1:0] burst_addr;
  int bad_count;
  int checks_done;

  sram_port_if #(.ADDR_W(AW), .DATA_W(DW)) i_sram_port_if ();
  sram_port_device #(.ADDR_W(AW), .DATA_W(DW)) i_sram_port_device (.aclk(aclk),
    .aresetn(aresetn), .port(i_sram_port_if), .power_down(power_down), .burst_addr(burst_addr));
  sram_port_host #(.ADDR_W(AW), .DATA_W(DW)) i_sram_port_host (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port(i_sram_port_if));
  sram_port_props #(.ADDR_W(AW)) i_sram_port_props (.aclk(aclk), .aresetn(aresetn),
    .clk_en(i_sram_port_if.clk_en), .addr(i_sram_port_if.addr),
    .addr_load_strobe_n(i_sram_port_if.addr_load_strobe_n),
    .chip_sel_lowactive(i_sram_port_if.chip_sel_lowactive),
    .chip_sel_highactive(i_sram_port_if.chip_sel_highactive),
    .burst_advance_n(i_sram_port_if.burst_advance_n),
    .burst_clear_n(i_sram_port_if.burst_clear_n), .oe_n(i_sram_port_if.oe_n),
    .wr_n(i_sram_port_if.wr_n), .latency_select(i_sram_port_if.latency_select),
    .dev_dq_oe_n(i_sram_port_if.dev_dq_oe_n), .power_down(power_down),
    .burst_addr(burst_addr));

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ****************************************************************
  // Report and compare
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic timed_out(input string what);
    $display("[FAIL] %s wait ran out", what);
    bad_count++;
    end_of_test();
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask

  // ****************************************************************
  // Register bus cycles
  // ****************************************************************
  // Valids drop only at the edge their own ready is seen, bready is held until bvalid
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
        break;
    end
    if (n >= 50)
      timed_out("write");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
        break;
    end
    if (n >= 50)
      timed_out("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One port access: address, data, command, wait for idle, then check rdone and read data for read commands
  task automatic mem_op(input logic [31:0] a, input logic [31:0] d, input logic [31:0] cmd,
    input logic [31:0] exp);
    logic [31:0] got;
    logic [1:0] r;
    int n;
    axi_write(sram_port_pkg::OFF_ADDR, a, r);
    axi_write(sram_port_pkg::OFF_WDATA, d, r);
    axi_write(sram_port_pkg::OFF_CMD, cmd, r);
    got = 32'hffff_ffff;
    for (n = 0; n < 20 && got[sram_port_pkg::STAT_BUSY_BIT] !== 1'b0; n++)
      axi_read(sram_port_pkg::OFF_STATUS, got, r);
    if (got[sram_port_pkg::STAT_BUSY_BIT] !== 1'b0)
      timed_out("busy");
    if (cmd[sram_port_pkg::CMD_WRITE_BIT] === 1'b0 && cmd[sram_port_pkg::CMD_DESEL_BIT] === 1'b0)
    begin
      check_word("rdone", 32'h0000_0001, 32'(got[sram_port_pkg::STAT_RDONE_BIT]));
      axi_read(sram_port_pkg::OFF_RDATA, got, r);
      check_word("rdata", exp, got);
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_map();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(sram_port_pkg::OFF_CTRL, d, r);
    check_word("ctrl", {30'h0000_0000, sram_port_pkg::CTRL_RESET}, d);
    axi_read(8'h40, d, r);
    check_resp("rresp", sram_port_pkg::RESP_SLVERR, r);
    check_word("unmapped rdata", 32'h0000_0000, d);
    axi_write(8'h40, 32'h0000_0001, r);
    check_resp("bresp", sram_port_pkg::RESP_SLVERR, r);
  endtask

  task automatic t_flow_through();
    logic [1:0] r;
    axi_write(sram_port_pkg::OFF_CTRL, 32'h0000_0000, r);
    mem_op(32'h0000_0010, 32'h0000_01a5, C_WR | C_LD, 32'h0000_0000);
    check_word("burst_addr", 32'h0000_0010, 32'(burst_addr));
    mem_op(32'h0000_0010, 32'h0000_0000, C_LD, 32'h0000_01a5);
  endtask

  task automatic t_burst_wrap();
    mem_op(32'h0000_7ffe, 32'h0000_00aa, C_WR | C_LD, 32'h0000_0000);
    mem_op(32'h0000_0000, 32'h0000_0155, C_WR | C_ADV, 32'h0000_0000);
    mem_op(32'h0000_0000, 32'h0000_00c3, C_WR | C_ADV, 32'h0000_0000);
    check_word("burst_addr", 32'h0000_0000, 32'(burst_addr));
    mem_op(32'h0000_7fff, 32'h0000_0000, C_LD, 32'h0000_0155);
    mem_op(32'h0000_7ffe, 32'h0000_0000, C_LD, 32'h0000_00aa);
  endtask

  task automatic t_clear_priority();
    mem_op(32'h0000_7ffe, 32'h0000_0000, C_CLR, 32'h0000_00c3);
    check_word("burst_addr", 32'h0000_0000, 32'(burst_addr));
    mem_op(32'h0000_7ffe, 32'h0000_0000, C_CLR | C_LD | C_ADV, 32'h0000_00c3);
    mem_op(32'h0000_7ffe, 32'h0000_0000, C_LD | C_ADV, 32'h0000_00aa);
  endtask

  task automatic t_pipelined();
    logic [1:0] r;
    axi_write(sram_port_pkg::OFF_CTRL, 32'h0000_0003, r);
    mem_op(32'h0000_0010, 32'h0000_0000, C_LD, 32'h0000_01a5);
    mem_op(32'h0000_0010, 32'h0000_0000, C_DES, 32'h0000_0000);
    check_word("power_down", 32'h0000_0001, 32'(power_down));
    mem_op(32'h0000_0010, 32'h0000_0000, C_LD, 32'h0000_01a5);
  endtask

  initial
  begin
    bad_count = 0;
    checks_done = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_flow_through();
    t_burst_wrap();
    t_clear_priority();
    t_pipelined();
    end_of_test();
  end
endmodule
